// file: src_regs.svh
// Overview of operation
// (R1) Dual-slope reset fires only when its enable bit is set.
// (R2) Triple-slope reset fires only when its enable bit is set.
// (R3) Horizontal mirror bit set reads pixels right to left.
// (R4) Vertical mirror bit set reads rows bottom to top.
// (R5) Non-destructive readout bit enables that mode; off by default.
// (R6) Column start counts groups of eight pixels, values 0 to 79.
// (R7) Row start selects any line 0 to 479 as first row.
// (R8) Width counts four-pixel kernels, 1 to 160; pixels equal four times.
// (R9) Pixel reset stays high for reset-length minus one lines; default 2.
// (R10) Dual-slope reset given after its position minus one lines.
// (R11) Triple-slope reset given after its position minus one lines.
// (R12) Frame transfer ends integration after its position minus one lines.
// (R13) Line interval is row overhead plus pixel count core clocks.
// (R14) Three 8-bit DAC codes drive DACs, zero highest, all ones lowest.
// (R15) ADC test path field: 0 none, 1 pixel one, 2 pixel two.
// (R16) ADC normal path field: all ones default, zero none, single paths.
// (R17) Mux bypass field bypasses output mux; zero means none.
// (R18) Gain code selects sixteen rising gains.
// (R19) Unity bit set forces unity gain, ignoring the gain code.
// (R20) Pre-attenuation bit clear applies half gain before the amplifier.
// (R21) Controller changes settings only in frame overhead or reset; here each write takes effect when it lands, mid-frame too.
// (R22) Serial word: address in bits 15:12, data in 11:0, loaded at enable.
// (R23) Line counter restarts at 1 after reset and after frame overhead.
// (R24) All fields reset to defaults and hold until rewritten.
`ifndef SRC_REGS_SVH
`define SRC_REGS_SVH
`define SRC_A_SEQ 4'h0
`define SRC_A_COL 4'h1
`define SRC_A_ROW 4'h2
`define SRC_A_KRN 4'h3
`define SRC_A_RES1 4'h4
`define SRC_A_RES2 4'h5
`define SRC_A_RES3 4'h6
`define SRC_A_FT 4'h7
`define SRC_A_VCAL 4'h8
`define SRC_A_VBLK 4'h9
`define SRC_A_VOFS 4'hA
`define SRC_A_ANA 4'hB
`define SRC_A_PGA 4'hC
`define SRC_D_SEQ 11'h029
`define SRC_D_COL 8'h00
`define SRC_D_ROW 9'h000
`define SRC_D_KRN 8'hA0
`define SRC_D_RES1 12'h002
`define SRC_D_RES2 12'h000
`define SRC_D_RES3 12'h000
`define SRC_D_FT 12'h1E1
`define SRC_D_VCAL 8'h4A
`define SRC_D_VBLK 8'h6B
`define SRC_D_VOFS 8'h55
`define SRC_D_ANA 12'h0F0
`define SRC_D_PGA 12'h7B0
`define SRC_B_GRAN_LO 2
`define SRC_B_GRAN_HI 3
`define SRC_B_DS_EN 6
`define SRC_B_TS_EN 7
`define SRC_B_REV_X 8
`define SRC_B_REV_Y 9
`define SRC_B_NDR 10
`define SRC_B_UNITY 4
`define SRC_B_SEL_UNI 5
`define SRC_ROT_CYC 11'h00C
`define SRC_CORE_DIV_MAX 2'h3
`define SRC_PULSE_EXTRA 6'h01
`define SRC_FOT_EXTRA 6'h02
`define SRC_LINE_FIRST 12'h001
`define SRC_PULSE_UNIT 6'h0C
`define SRC_PGA_INV 12'h020
`endif

// file: src_pkg.sv
package src_pkg;
   typedef enum logic [0:0] {
      SRC_S_READ = 1'b0,
      SRC_S_FOT = 1'b1
   } src_state_e;
   typedef logic [11:0] src_line_t;
endpackage : src_pkg

// file: src_config_regs.sv
`timescale 1ns/1ps
`include "src_regs.svh"
module src_config_regs (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic spi_clk,
   input wire logic spi_data,
   input wire logic spi_load,
   output logic frame_valid,
   output logic frame_transfer,
   output logic pixel_reset,
   output logic dual_slope_reset,
   output logic triple_slope_reset,
   output src_pkg::src_line_t line_count,
   output logic mirror_x,
   output logic mirror_y,
   output logic ndr_en,
   output logic [9:0] col_start_pixel,
   output logic [8:0] row_start,
   output logic [9:0] line_pixels,
   output logic [7:0] cal_dac,
   output logic [7:0] black_dac,
   output logic [7:0] offset_dac,
   output logic [3:0] adc_test_path,
   output logic [3:0] adc_norm_path,
   output logic [3:0] mux_bypass,
   output logic [3:0] gain_code,
   output logic pga_unity,
   output logic pre_atten_en
);
   import src_pkg::*;

   function automatic logic [10:0] src_line_len(input logic [7:0] k);
      return `SRC_ROT_CYC + {1'b0, k, 2'b00};
   endfunction : src_line_len

   function automatic logic [5:0] src_pulse_len(input logic [1:0] g, input logic [5:0] x);
      return (({4'h0, g} + 6'h01) * `SRC_PULSE_UNIT) + x;
   endfunction : src_pulse_len

   ////////////////////////////////////////////////////////////////////////
   // Link domain: shift in, hold word, toggle at load
   logic rs1_q, rs2_q;
   logic [15:0] shift_q, shift_d;
   logic [15:0] word_q, word_d;
   logic tog_q, tog_d;

   always_ff @(posedge spi_clk)
   begin
      rs1_q <= rst_n;
      rs2_q <= rs1_q;
   end

   always_comb
   begin
      shift_d = {shift_q[14:0], spi_data};
      word_d = word_q;
      tog_d = tog_q;
      if (spi_load)
      begin
         word_d = shift_q; // R22
         tog_d = ~tog_q;
      end
   end

   always_ff @(posedge spi_clk)
   begin
      if (!rs2_q)
      begin
         shift_q <= 16'h0000;
         word_q <= 16'h0000;
         tog_q <= 1'b0;
      end
      else
      begin
         shift_q <= shift_d;
         word_q <= word_d;
         tog_q <= tog_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Toggle crossing; word is stable long before the toggle lands
   logic ts1_q, ts2_q, ts3_q;
   logic wr_stb;
   logic [3:0] wr_addr;
   logic [11:0] wr_data;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         ts1_q <= 1'b0;
         ts2_q <= 1'b0;
         ts3_q <= 1'b0;
      end
      else
      begin
         ts1_q <= tog_q;
         ts2_q <= ts1_q;
         ts3_q <= ts2_q;
      end
   end

   assign wr_stb = ts2_q ^ ts3_q;
   assign wr_addr = word_q[15:12];
   assign wr_data = word_q[11:0];

   ////////////////////////////////////////////////////////////////////////
   // Register bank; addresses 13 to 15 are dropped
   logic [10:0] seq_q, seq_d;
   logic [7:0] col_q, col_d;
   logic [8:0] row_q, row_d;
   logic [7:0] krn_q, krn_d;
   logic [11:0] res1_q, res1_d, res2_q, res2_d, res3_q, res3_d, ft_q, ft_d;
   logic [7:0] vcal_q, vcal_d, vblk_q, vblk_d, vofs_q, vofs_d;
   logic [11:0] ana_q, ana_d, pga_q, pga_d;

   always_comb
   begin
      seq_d = seq_q;
      col_d = col_q;
      row_d = row_q;
      krn_d = krn_q;
      res1_d = res1_q;
      res2_d = res2_q;
      res3_d = res3_q;
      ft_d = ft_q;
      vcal_d = vcal_q;
      vblk_d = vblk_q;
      vofs_d = vofs_q;
      ana_d = ana_q;
      pga_d = pga_q;
      if (wr_stb) // R22 R24
      begin
         case (wr_addr)
            `SRC_A_SEQ: seq_d = wr_data[10:0];
            `SRC_A_COL: col_d = wr_data[7:0]; // R6
            `SRC_A_ROW: row_d = wr_data[8:0]; // R7
            `SRC_A_KRN: krn_d = wr_data[7:0]; // R8
            `SRC_A_RES1: res1_d = wr_data;
            `SRC_A_RES2: res2_d = wr_data;
            `SRC_A_RES3: res3_d = wr_data;
            `SRC_A_FT: ft_d = wr_data;
            `SRC_A_VCAL: vcal_d = wr_data[7:0]; // R14
            `SRC_A_VBLK: vblk_d = wr_data[7:0]; // R14
            `SRC_A_VOFS: vofs_d = wr_data[7:0]; // R14
            `SRC_A_ANA: ana_d = wr_data; // R15 R16 R17
            `SRC_A_PGA: pga_d = wr_data ^ `SRC_PGA_INV; // R18 R19 R20
            default: seq_d = seq_q;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n) // R24
      begin
         seq_q <= `SRC_D_SEQ;
         col_q <= `SRC_D_COL;
         row_q <= `SRC_D_ROW;
         krn_q <= `SRC_D_KRN;
         res1_q <= `SRC_D_RES1;
         res2_q <= `SRC_D_RES2;
         res3_q <= `SRC_D_RES3;
         ft_q <= `SRC_D_FT;
         vcal_q <= `SRC_D_VCAL;
         vblk_q <= `SRC_D_VBLK;
         vofs_q <= `SRC_D_VOFS;
         ana_q <= `SRC_D_ANA;
         pga_q <= `SRC_D_PGA ^ `SRC_PGA_INV;
      end
      else
      begin
         seq_q <= seq_d;
         col_q <= col_d;
         row_q <= row_d;
         krn_q <= krn_d;
         res1_q <= res1_d;
         res2_q <= res2_d;
         res3_q <= res3_d;
         ft_q <= ft_d;
         vcal_q <= vcal_d;
         vblk_q <= vblk_d;
         vofs_q <= vofs_d;
         ana_q <= ana_d;
         pga_q <= pga_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Line sequencer, stepped by the divided core tick
   src_state_e st_q, st_d;
   logic [1:0] div_q, div_d;
   logic [10:0] tick_q, tick_d;
   logic [11:0] line_q, line_d;
   logic [5:0] fot_q, fot_d, ds_q, ds_d, ts_q, ts_d;
   logic core_tick, line_end, ft_hit, ds_hit, ts_hit;
   logic [11:0] line_nx;
   logic [1:0] gran;

   assign gran = seq_q[`SRC_B_GRAN_HI:`SRC_B_GRAN_LO];
   assign core_tick = (div_q == `SRC_CORE_DIV_MAX);
   assign line_end = core_tick && (st_q == SRC_S_READ)
                     && (tick_q == src_line_len(krn_q) - 11'h001); // R13
   assign line_nx = line_q + 12'h001;
   assign ft_hit = line_end && (line_nx == ft_q); // R12
   assign ds_hit = line_end && (line_nx == res2_q) && seq_q[`SRC_B_DS_EN]; // R1 R10
   assign ts_hit = line_end && (line_nx == res3_q) && seq_q[`SRC_B_TS_EN]; // R2 R11

   always_comb
   begin
      div_d = div_q + 2'h1;
      st_d = st_q;
      tick_d = tick_q;
      line_d = line_q;
      fot_d = fot_q;
      ds_d = ds_q;
      ts_d = ts_q;
      if (core_tick)
      begin
         if (ds_q != 6'h00)
            ds_d = ds_q - 6'h01;
         if (ts_q != 6'h00)
            ts_d = ts_q - 6'h01;
         if (ds_hit)
            ds_d = src_pulse_len(gran, `SRC_PULSE_EXTRA);
         if (ts_hit)
            ts_d = src_pulse_len(gran, `SRC_PULSE_EXTRA);
         case (st_q)
            SRC_S_READ:
            begin
               tick_d = tick_q + 11'h001;
               if (line_end)
               begin
                  tick_d = 11'h000;
                  line_d = line_nx;
               end
               if (ft_hit)
               begin
                  st_d = SRC_S_FOT;
                  fot_d = src_pulse_len(gran, `SRC_FOT_EXTRA);
               end
            end
            SRC_S_FOT:
            begin
               fot_d = fot_q - 6'h01;
               if (fot_q == 6'h01)
               begin
                  st_d = SRC_S_READ;
                  tick_d = 11'h000;
                  line_d = `SRC_LINE_FIRST; // R23
               end
            end
            default: st_d = SRC_S_READ;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         st_q <= SRC_S_READ;
         div_q <= 2'h0;
         tick_q <= 11'h000;
         line_q <= `SRC_LINE_FIRST; // R23
         fot_q <= 6'h00;
         ds_q <= 6'h00;
         ts_q <= 6'h00;
      end
      else
      begin
         st_q <= st_d;
         div_q <= div_d;
         tick_q <= tick_d;
         line_q <= line_d;
         fot_q <= fot_d;
         ds_q <= ds_d;
         ts_q <= ts_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Timing outputs, registered; a slope pulse dies if its enable drops
   logic fv_q, ftr_q, prst_q, dso_q, tso_q;
   logic fv_d, ftr_d, prst_d, dso_d, tso_d;

   always_comb
   begin
      fv_d = (st_q == SRC_S_READ);
      ftr_d = (st_q == SRC_S_FOT); // R12
      prst_d = (st_q == SRC_S_READ) && (line_q < res1_q); // R9
      dso_d = (ds_q != 6'h00) && seq_q[`SRC_B_DS_EN]; // R1
      tso_d = (ts_q != 6'h00) && seq_q[`SRC_B_TS_EN]; // R2
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         fv_q <= 1'b0;
         ftr_q <= 1'b0;
         prst_q <= 1'b0;
         dso_q <= 1'b0;
         tso_q <= 1'b0;
      end
      else
      begin
         fv_q <= fv_d;
         ftr_q <= ftr_d;
         prst_q <= prst_d;
         dso_q <= dso_d;
         tso_q <= tso_d;
      end
   end

   assign frame_valid = fv_q;
   assign frame_transfer = ftr_q;
   assign pixel_reset = prst_q;
   assign dual_slope_reset = dso_q;
   assign triple_slope_reset = tso_q;
   assign line_count = line_q;
   assign mirror_x = seq_q[`SRC_B_REV_X]; // R3
   assign mirror_y = seq_q[`SRC_B_REV_Y]; // R4
   assign ndr_en = seq_q[`SRC_B_NDR]; // R5
   assign col_start_pixel = {col_q[6:0], 3'b000}; // R6
   assign row_start = row_q; // R7
   assign line_pixels = {krn_q, 2'b00}; // R8
   assign cal_dac = vcal_q; // R14
   assign black_dac = vblk_q;
   assign offset_dac = vofs_q;
   assign adc_test_path = ana_q[3:0]; // R15
   assign adc_norm_path = ana_q[7:4]; // R16
   assign mux_bypass = ana_q[11:8]; // R17
   assign gain_code = pga_q[3:0]; // R18
   assign pga_unity = pga_q[`SRC_B_UNITY]; // R19
   // Select bit held inverted so the enable leaves a flop directly
   assign pre_atten_en = pga_q[`SRC_B_SEL_UNI]; // R20

   ////////////////////////////////////////////////////////////////////////
   property p_ds_gate;
      @(posedge sys_clk) disable iff (!rst_n)
      dual_slope_reset |-> $past(seq_q[`SRC_B_DS_EN]);
   endproperty
   a_ds_gate: assert property (p_ds_gate) else $error("dual slope without enable"); // R1

   property p_ts_gate;
      @(posedge sys_clk) disable iff (!rst_n)
      triple_slope_reset |-> $past(seq_q[`SRC_B_TS_EN]);
   endproperty
   a_ts_gate: assert property (p_ts_gate) else $error("triple slope without enable"); // R2

   property p_mirror;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_stb && wr_addr == `SRC_A_SEQ) |=> (mirror_x == $past(wr_data[`SRC_B_REV_X]))
         && (mirror_y == $past(wr_data[`SRC_B_REV_Y]));
   endproperty
   a_mirror: assert property (p_mirror) else $error("mirror bits not loaded"); // R3

   property p_col;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_stb && wr_addr == `SRC_A_COL) |=> col_start_pixel == {$past(wr_data[6:0]), 3'b000};
   endproperty
   a_col: assert property (p_col) else $error("column start wrong"); // R6

   property p_prst;
      @(posedge sys_clk) disable iff (!rst_n)
      ($fell(pixel_reset) && frame_valid) |-> (line_count == res1_q);
   endproperty
   a_prst: assert property (p_prst) else $error("pixel reset low early"); // R9

   property p_line_one;
      @(posedge sys_clk) disable iff (!rst_n)
      (st_q == SRC_S_FOT && core_tick && fot_q == 6'h01) |=> line_q == `SRC_LINE_FIRST
         && frame_valid == 1'b0 ##1 frame_valid;
   endproperty
   a_line_one: assert property (p_line_one) else $error("line count not restarted"); // R23

   property p_ft;
      @(posedge sys_clk) disable iff (!rst_n)
      ft_hit |=> ##1 (frame_transfer && !frame_valid);
   endproperty
   a_ft: assert property (p_ft) else $error("frame transfer missing"); // R12

   property p_line_len;
      @(posedge sys_clk) disable iff (!rst_n)
      line_end |=> (tick_q == 11'h000) && (line_q == $past(line_q) + 12'h001);
   endproperty
   a_line_len: assert property (p_line_len) else $error("line end wrong"); // R13

   property p_unity;
      @(posedge sys_clk) disable iff (!rst_n)
      (wr_stb && wr_addr == `SRC_A_PGA) |=> (pga_unity == $past(wr_data[`SRC_B_UNITY]))
         && (pre_atten_en == !$past(wr_data[`SRC_B_SEL_UNI]));
   endproperty
   a_unity: assert property (p_unity) else $error("amplifier bits not loaded"); // R19
endmodule : src_config_regs

// file: src_spi_host.sv
`timescale 1ns/1ps
module src_spi_host (
   input wire logic hold_run,
   output logic spi_clk,
   output logic spi_data,
   output logic spi_load
);
   logic run;
   initial
   begin
      spi_clk = 1'b0;
      spi_data = 1'b0;
      spi_load = 1'b0;
      run = 1'b0;
      #3.3;
      forever
      begin
         #7.5;
         // Link clock parks low between words
         if (run || hold_run || spi_clk)
            spi_clk = ~spi_clk;
      end
   end
   ////////////////////////////////////////////////////////////
   // Three lead bits let the link-side reset copy settle first
   task automatic send(input logic [3:0] addr, input logic [11:0] data);
      logic [15:0] w;
      w = {addr, data};
      run = 1'b1;
      for (int i = 0; i < 21; i++)
      begin
         @(negedge spi_clk);
         // Idle bits toggle so a stale level never looks valid
         spi_data = (i >= 3 && i < 19) ? w[18 - i] : ~spi_data;
         spi_load = (i == 19);
      end
      run = 1'b0;
   endtask : send
endmodule : src_spi_host

// file: src_config_regs_bench.sv
`timescale 1ns/1ps
`include "src_regs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module src_config_regs_bench;
   import src_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hold_run = 1'b1;
   logic spi_clk, spi_data, spi_load;
   logic frame_valid, frame_transfer, pixel_reset, dual_slope_reset, triple_slope_reset;
   src_line_t line_count;
   logic mirror_x, mirror_y, ndr_en, pga_unity, pre_atten_en;
   logic [9:0] col_start_pixel, line_pixels;
   logic [8:0] row_start;
   logic [7:0] cal_dac, black_dac, offset_dac;
   logic [3:0] adc_test_path, adc_norm_path, mux_bypass, gain_code;
   int num_errors = 0;
   int n_tests = 0;
   int m[13] = '{`SRC_D_SEQ, `SRC_D_COL, `SRC_D_ROW, `SRC_D_KRN, `SRC_D_RES1, `SRC_D_RES2,
      `SRC_D_RES3, `SRC_D_FT, `SRC_D_VCAL, `SRC_D_VBLK, `SRC_D_VOFS, `SRC_D_ANA, `SRC_D_PGA};
   int wd[13] = '{11, 8, 9, 8, 12, 12, 12, 12, 8, 8, 8, 12, 12};
   int adr[12] = '{1, 2, 8, 9, 10, 11, 12, 13, 14, 15, 0, 12};
   int a, d, gran, cyc, fot_c, ds_c, ts_c, ds_n, ts_n;
   logic [15:0] rnd = 16'h9AD6;
   logic watch = 1'b0;
   logic lc_seen = 1'b0;
   logic pfv, pft, ppr, pds, pts;
   src_line_t plc;
   always #25 sys_clk = ~sys_clk;
   src_spi_host host (.hold_run(hold_run), .spi_clk(spi_clk), .spi_data(spi_data),
      .spi_load(spi_load));
   src_config_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .spi_clk(spi_clk),
      .spi_data(spi_data), .spi_load(spi_load), .frame_valid(frame_valid),
      .frame_transfer(frame_transfer), .pixel_reset(pixel_reset),
      .dual_slope_reset(dual_slope_reset), .triple_slope_reset(triple_slope_reset),
      .line_count(line_count), .mirror_x(mirror_x), .mirror_y(mirror_y), .ndr_en(ndr_en),
      .col_start_pixel(col_start_pixel), .row_start(row_start), .line_pixels(line_pixels),
      .cal_dac(cal_dac), .black_dac(black_dac), .offset_dac(offset_dac),
      .adc_test_path(adc_test_path), .adc_norm_path(adc_norm_path), .mux_bypass(mux_bypass),
      .gain_code(gain_code), .pga_unity(pga_unity), .pre_atten_en(pre_atten_en));
   ////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next
   task automatic close_out();
      $display("mismatches %0d, comparisons %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   task automatic check_cfg();
      `CHK("mirror_x", 1'(m[0] >> 8), mirror_x)
      `CHK("mirror_y", 1'(m[0] >> 9), mirror_y)
      `CHK("ndr", 1'(m[0] >> 10), ndr_en)
      `CHK("col", 10'(8 * m[1]), col_start_pixel)
      `CHK("row", 9'(m[2]), row_start)
      `CHK("pixels", 10'(4 * m[3]), line_pixels)
      `CHK("cal", 8'(m[8]), cal_dac)
      `CHK("black", 8'(m[9]), black_dac)
      `CHK("offset", 8'(m[10]), offset_dac)
      `CHK("test_path", 4'(m[11]), adc_test_path)
      `CHK("norm_path", 4'(m[11] >> 4), adc_norm_path)
      `CHK("bypass", 4'(m[11] >> 8), mux_bypass)
      `CHK("gain", 4'(m[12]), gain_code)
      `CHK("unity", 1'(m[12] >> 4), pga_unity)
      `CHK("pre_atten", 1'(~(m[12] >> 5)), pre_atten_en)
   endtask : check_cfg
   // Addresses past 12 must leave every field untouched
   task automatic wr(input int wa, input int wv);
      host.send(4'(wa), 12'(wv));
      if (wa < 13)
         m[wa] = wv & ((1 << wd[wa]) - 1);
      repeat (8) @(negedge sys_clk);
      check_cfg();
   endtask : wr
   ////////////////////////////////////////////////////////////
   always @(negedge sys_clk)
   begin
      gran = (m[0] >> 2) & 3;
      if (watch)
      begin
         if (frame_transfer && !pft)
            `CHK("ft_line", src_line_t'(m[7]), line_count)
         if (frame_valid && !pfv)
         begin
            `CHK("fot_len", 4 * (12 * (gran + 1) + 2), fot_c)
            `CHK("first_line", 12'h001, line_count)
         end
         if (!pixel_reset && ppr && frame_valid)
            `CHK("res_end", src_line_t'(m[4]), line_count)
         if (dual_slope_reset && !pds)
            `CHK("ds_line", src_line_t'(m[5]), line_count)
         if (!dual_slope_reset && pds)
            `CHK("ds_len", 4 * (12 * (gran + 1) + 1), ds_c)
         if (triple_slope_reset && !pts)
            `CHK("ts_line", src_line_t'(m[6]), line_count)
         if (!triple_slope_reset && pts)
            `CHK("ts_len", 4 * (12 * (gran + 1) + 1), ts_c)
         if (line_count != plc && lc_seen && line_count == plc + 1)
            `CHK("line_len", 4 * (12 + 4 * m[3]), cyc)
      end
      ds_n += (dual_slope_reset && !pds);
      ts_n += (triple_slope_reset && !pts);
      if (line_count != plc)
      begin
         cyc = 1;
         lc_seen = watch;
      end
      else
         cyc++;
      fot_c = frame_valid ? 0 : fot_c + 1;
      ds_c = dual_slope_reset ? ds_c + 1 : 0;
      ts_c = triple_slope_reset ? ts_c + 1 : 0;
      {pfv, pft, ppr, pds, pts} = {frame_valid, frame_transfer, pixel_reset,
         dual_slope_reset, triple_slope_reset};
      plc = line_count;
   end
   initial
   begin
      repeat (40000) @(posedge sys_clk);
      num_errors++;
      close_out();
   end
   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (16) @(negedge sys_clk);
      check_cfg();
      `CHK("lc_rst", 12'h001, line_count)
      `CHK("fv_rst", 1'b0, frame_valid)
      rst_n = 1'b1;
      hold_run = 1'b0;
      @(negedge sys_clk);
      `CHK("fv_go", 1'b1, frame_valid)
      wait (line_count == 12'h002);
      // Short frames keep the run brief; this setup lands mid-frame deliberately
      wr(3, 1);
      wr(7, 5);
      wr(4, 3);
      wr(5, 3);
      wr(6, 4);
      @(negedge frame_valid);
      @(posedge frame_valid);
      watch = 1'b1;
      ds_n = 0;
      ts_n = 0;
      repeat (2) @(posedge frame_transfer);
      `CHK("ds_off", 0, ds_n)
      `CHK("ts_off", 0, ts_n)
      wr(0, 'h0E9 | (rnd & 'h700));
      ds_n = 0;
      ts_n = 0;
      repeat (2) @(posedge frame_transfer);
      `CHK("ds_active", 2, ds_n)
      `CHK("ts_active", 2, ts_n)
      // Slope enables stay set: pulses still run into overhead and must not be cut
      for (int k = 0; k < 12; k++)
      begin
         @(posedge frame_transfer);
         rnd = lfsr_next(rnd);
         a = adr[k];
         d = (a == 1) ? rnd % 80 : (a == 2) ? rnd % 480 : (a == 0) ? (rnd & 'h700) | 'hE9 : rnd;
         wr(a, d);
      end
      @(posedge frame_transfer);
      wr(1, 79);
      wr(2, 479);
      close_out();
   end
endmodule : src_config_regs_bench
